// >>> csfp_core.sv
// Program counter low byte, table lookup pointers and status flags with APB access
`timescale 1ns/10ps
`default_nettype none
module csfp_core (
    input wire logic clock, // 100 MHz clock
    input wire logic rst, // Synchronous reset, active high
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB write
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    input wire csfp_pkg::csfp_alu_req_t aluReq, // ALU operation request
    output logic [7:0] aluResult, // Registered ALU result
    input wire logic pcStep, // Advance program counter by one
    output logic [csfp_pkg::PC_W-1:0] pc, // Program counter
    output logic dummyCycle, // Dummy cycle after a computed jump
    input wire logic halt, // Halt instruction executes
    input wire logic wdtRefresh, // Watchdog refresh instruction executes
    input wire logic wdtTimeout, // Watchdog timer expired
    input wire logic tblReadReq, // Table read instruction
    input wire logic [7:0] tblDest, // Data memory target of table read
    output logic [csfp_pkg::PC_W-1:0] pmAddr, // Program memory address
    output logic pmRead, // Program memory read strobe
    input wire logic [15:0] pmData, // Program memory word, one cycle after pmRead
    output logic dmWrite, // Data memory write strobe
    output logic [7:0] dmAddr, // Data memory address
    output logic [7:0] dmData, // Data memory write data
    output logic irq // Interrupt, level
);
    import csfp_pkg::*;

    logic pready_q, pready_d, pslverr_q, pslverr_d;
    logic [31:0] prdata_q, prdata_d, rdData;
    logic hit, accEnd, wr, wrPcl, wrStat;
    logic [PC_W-1:0] pc_q, pc_d;
    logic dummy_q, dummy_d;
    logic [7:0] table_pointer_low_q, table_pointer_low_d, table_high_byte_q, table_high_byte_d;
    logic [TABLE_POINTER_HIGH_W-1:0] table_pointer_high_q, table_pointer_high_d;
    logic [3:0] flags_q, flags_d;
    logic pdf_q, pdf_d, to_q, to_d;
    logic [EV_W-1:0] evt_q, evt_d, mask_q, mask_d, evtSet;
    logic irq_q, irq_d;
    logic [7:0] res_q, res_d;
    csfp_tr_state_t tr_q, tr_d;
    logic [PC_W-1:0] pmAddr_q, pmAddr_d;
    logic pmRead_q, pmRead_d, dmWr_q, dmWr_d;
    logic [7:0] dmAddr_q, dmAddr_d, dmData_q, dmData_d, dest_q, dest_d;
    logic [7:0] aluRes;
    csfp_flags_t aluFlags;
    logic [3:0] aluUpd;

    csfp_flag_calc u_calc (
        .op(aluReq.op),
        .a(aluReq.a),
        .b(aluReq.b),
        .carryIn(flags_q[ST_C]),
        .result(aluRes),
        .flags(aluFlags),
        .update(aluUpd)
    );

    // APB slave: one wait state, write lands at the ready edge
    always_comb begin
        hit = 1'b1;
        rdData = 32'h0000_0000;
        if (paddr == ADDR_PCL) begin
            rdData[7:0] = pc_q[7:0];
        end else if (paddr == ADDR_TABLE_POINTER_LOW) begin
            rdData[7:0] = table_pointer_low_q;
        end else if (paddr == ADDR_TABLE_POINTER_HIGH) begin
            rdData[TABLE_POINTER_HIGH_W-1:0] = table_pointer_high_q;
        end else if (paddr == ADDR_TABLE_HIGH_BYTE) begin
            rdData[7:0] = table_high_byte_q;
        end else if (paddr == ADDR_STATUS) begin
            rdData[ST_TO:0] = {to_q, pdf_q, flags_q};
        end else if (paddr == ADDR_EVT) begin
            rdData[EV_W-1:0] = evt_q;
        end else if (paddr == ADDR_MASK) begin
            rdData[EV_W-1:0] = mask_q;
        end else if (paddr == ADDR_PC) begin
            rdData[PC_W-1:0] = pc_q;
        end else begin
            hit = 1'b0;
        end
        pready_d = psel && penable && !pready_q;
        pslverr_d = pready_d && !hit;
        prdata_d = (pready_d && !pwrite) ? rdData : 32'h0000_0000;
        accEnd = psel && penable && pready_q;
        wr = accEnd && pwrite && !pslverr_q;
        wrPcl = wr && (paddr == ADDR_PCL);
        wrStat = wr && (paddr == ADDR_STATUS);
    end

    // Program counter and jump handling
    always_comb begin
        pc_d = pc_q;
        dummy_d = 1'b0;
        if (wrPcl) begin
            pc_d = {pc_q[PC_W-1:8], pwdata[7:0]};
            dummy_d = 1'b1;
        end else if (pcStep && !dummy_q) begin
            pc_d = pc_q + 13'h0001;
        end
    end

    // Table pointers and table read sequence
    always_comb begin
        table_pointer_low_d = table_pointer_low_q;
        table_pointer_high_d = table_pointer_high_q;
        table_high_byte_d = table_high_byte_q;
        tr_d = tr_q;
        pmAddr_d = pmAddr_q;
        pmRead_d = 1'b0;
        dmWr_d = 1'b0;
        dmAddr_d = dmAddr_q;
        dmData_d = dmData_q;
        dest_d = dest_q;
        if (wr && paddr == ADDR_TABLE_POINTER_LOW) begin
            table_pointer_low_d = pwdata[7:0];
        end
        if (wr && paddr == ADDR_TABLE_POINTER_HIGH) begin
            table_pointer_high_d = pwdata[TABLE_POINTER_HIGH_W-1:0];
        end
        case (tr_q)
            TR_IDLE: begin
                if (tblReadReq) begin
                    pmAddr_d = {table_pointer_high_q, table_pointer_low_q};
                    pmRead_d = 1'b1;
                    dest_d = tblDest;
                    tr_d = TR_WAIT;
                end
            end
            TR_WAIT: begin
                tr_d = TR_CATCH;
            end
            TR_CATCH: begin
                table_high_byte_d = pmData[15:8];
                dmWr_d = 1'b1;
                dmAddr_d = dest_q;
                dmData_d = pmData[7:0];
                tr_d = TR_IDLE;
            end
            default: begin
                tr_d = TR_IDLE;
            end
        endcase
    end

    // Status register; nothing here pushes it anywhere on interrupt or call
    always_comb begin
        res_d = res_q;
        flags_d = flags_q;
        if (aluReq.valid) begin
            res_d = aluRes;
            for (int i = 0; i < 4; i++) begin
                if (aluUpd[i]) begin
                    flags_d[i] = aluFlags[i];
                end
            end
        end
        if (wrStat) begin
            flags_d = pwdata[ST_OV:ST_C];
        end
        // Status writes never reach these two bits
        pdf_d = pdf_q;
        to_d = to_q;
        if (wdtRefresh) begin
            pdf_d = 1'b0;
            to_d = 1'b0;
        end
        if (halt) begin
            pdf_d = 1'b1;
            to_d = 1'b0;
        end
        if (wdtTimeout) begin
            to_d = 1'b1;
        end
    end

    // Sticky events, write one to clear; a new event wins over the clear
    always_comb begin
        evtSet = '0;
        evtSet[EV_JUMP] = wrPcl;
        evtSet[EV_TBL] = (tr_q == TR_CATCH);
        evtSet[EV_WDT] = wdtTimeout;
        evtSet[EV_HALT] = halt;
        mask_d = mask_q;
        evt_d = evt_q;
        if (wr && paddr == ADDR_MASK) begin
            mask_d = pwdata[EV_W-1:0];
        end
        if (wr && paddr == ADDR_EVT) begin
            evt_d = evt_q & ~pwdata[EV_W-1:0];
        end
        evt_d = evt_d | evtSet;
        irq_d = |(evt_d & mask_d);
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            pc_q <= PC_RST;
            dummy_q <= 1'b0;
            table_pointer_low_q <= PTR_RST;
            table_pointer_high_q <= '0;
            table_high_byte_q <= PTR_RST;
            tr_q <= TR_IDLE;
            pmAddr_q <= PC_RST;
            pmRead_q <= 1'b0;
            dmWr_q <= 1'b0;
            dmAddr_q <= PTR_RST;
            dmData_q <= PTR_RST;
            dest_q <= PTR_RST;
            flags_q <= FLAGS_RST;
            pdf_q <= 1'b0;
            to_q <= 1'b0;
            res_q <= PTR_RST;
            evt_q <= EV_RST;
            mask_q <= EV_RST;
            irq_q <= 1'b0;
        end else begin
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q <= prdata_d;
            pc_q <= pc_d;
            dummy_q <= dummy_d;
            table_pointer_low_q <= table_pointer_low_d;
            table_pointer_high_q <= table_pointer_high_d;
            table_high_byte_q <= table_high_byte_d;
            tr_q <= tr_d;
            pmAddr_q <= pmAddr_d;
            pmRead_q <= pmRead_d;
            dmWr_q <= dmWr_d;
            dmAddr_q <= dmAddr_d;
            dmData_q <= dmData_d;
            dest_q <= dest_d;
            flags_q <= flags_d;
            pdf_q <= pdf_d;
            to_q <= to_d;
            res_q <= res_d;
            evt_q <= evt_d;
            mask_q <= mask_d;
            irq_q <= irq_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign aluResult = res_q;
    assign pc = pc_q;
    assign dummyCycle = dummy_q;
    assign pmAddr = pmAddr_q;
    assign pmRead = pmRead_q;
    assign dmWrite = dmWr_q;
    assign dmAddr = dmAddr_q;
    assign dmData = dmData_q;
    assign irq = irq_q;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    pcl_jump_a: assert property (wrPcl |=> pc_q[7:0] == $past(pwdata[7:0]) && pc_q[12:8] == $past(pc_q[12:8]))
        else $error("PC low byte jump wrong");
    dummy_slot_a: assert property (wrPcl |=> dummyCycle ##1 (!dummyCycle || $past(wrPcl)))
        else $error("Dummy cycle missing or too long");
    dummy_hold_a: assert property (dummy_q && !wrPcl |=> pc_q == $past(pc_q))
        else $error("PC moved during dummy cycle");
    tbl_addr_a: assert property (tblReadReq && tr_q == TR_IDLE |=> pmRead && pmAddr == {$past(table_pointer_high_q), $past(table_pointer_low_q)})
        else $error("Table read address wrong");
    tbl_data_a: assert property (pmRead |=> ##1 table_high_byte_q == $past(pmData[15:8]) && dmWrite && dmData == $past(pmData[7:0]))
        else $error("Table read data wrong");
    stat_write_a: assert property (wrStat |=> flags_q == $past(pwdata[3:0]))
        else $error("Status write did not land");
    stat_ro_a: assert property (wrStat && !halt && !wdtRefresh && !wdtTimeout |=> $stable(pdf_q) && $stable(to_q))
        else $error("Status write touched read-only flags");
    add_carry_a: assert property (aluReq.valid && aluReq.op == OP_ADD && !wrStat
        |=> flags_q[ST_C] == $past(9'(aluReq.a) + 9'(aluReq.b) > 9'h0ff))
        else $error("Carry flag wrong after add");
    add_nibble_a: assert property (aluReq.valid && aluReq.op == OP_ADD && !wrStat
        |=> flags_q[ST_AC] == $past(5'(aluReq.a[3:0]) + 5'(aluReq.b[3:0]) > 5'h0f))
        else $error("Nibble carry wrong after add");
    and_zero_a: assert property (aluReq.valid && aluReq.op == OP_AND && !wrStat
        |=> flags_q[ST_Z] == $past((aluReq.a & aluReq.b) == 8'h00))
        else $error("Zero flag wrong after and");
    add_ovf_a: assert property (aluReq.valid && aluReq.op == OP_ADD && !wrStat
        |=> flags_q[ST_OV] == $past(aluReq.a[7] == aluReq.b[7]
        && ((aluReq.a ^ 8'(aluReq.a + aluReq.b)) & 8'h80) != 8'h00))
        else $error("Overflow flag wrong after add");
    pdf_track_a: assert property ((halt |=> pdf_q) and (wdtRefresh && !halt |=> !pdf_q))
        else $error("Power-down flag wrong");
    to_track_a: assert property ((wdtTimeout |=> to_q) and ((halt || wdtRefresh) && !wdtTimeout |=> !to_q))
        else $error("Watchdog expiry flag wrong");

endmodule
`default_nettype wire

// >>> csfp_pkg.sv
// Shared constants, types and register map of the CPU status flags and pointers block
package csfp_pkg;

    localparam int PC_W = 13;
    localparam int TABLE_POINTER_HIGH_W = PC_W - 8;
    localparam int EV_W = 4;

    // Register byte offsets on APB
    localparam logic [7:0] ADDR_PCL = 8'h00;
    localparam logic [7:0] ADDR_TABLE_POINTER_LOW = 8'h04;
    localparam logic [7:0] ADDR_TABLE_POINTER_HIGH = 8'h08;
    localparam logic [7:0] ADDR_TABLE_HIGH_BYTE = 8'h0c;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_EVT = 8'h14;
    localparam logic [7:0] ADDR_MASK = 8'h18;
    localparam logic [7:0] ADDR_PC = 8'h1c;

    // Status field positions
    localparam int ST_C = 0;
    localparam int ST_AC = 1;
    localparam int ST_Z = 2;
    localparam int ST_OV = 3;
    localparam int ST_PDF = 4;
    localparam int ST_TO = 5;

    // Event field positions
    localparam int EV_JUMP = 0;
    localparam int EV_TBL = 1;
    localparam int EV_WDT = 2;
    localparam int EV_HALT = 3;

    // Reset values
    localparam logic [PC_W-1:0] PC_RST = 13'h0000;
    localparam logic [7:0] PTR_RST = 8'h00;
    localparam logic [3:0] FLAGS_RST = 4'h0;
    localparam logic [EV_W-1:0] EV_RST = 4'h0;

    // Which flags each class of operation updates
    localparam logic [3:0] UPD_ARITH = 4'hf;
    localparam logic [3:0] UPD_ROT = 4'h1;
    localparam logic [3:0] UPD_LOGIC = 4'h4;

    typedef enum logic [3:0] {
        OP_ADD = 4'h0,
        OP_ADC = 4'h1,
        OP_SUB = 4'h2,
        OP_SBC = 4'h3,
        OP_RLC = 4'h4,
        OP_RRC = 4'h5,
        OP_AND = 4'h6,
        OP_OR = 4'h7,
        OP_XOR = 4'h8
    } csfp_op_t;

    typedef enum logic [2:0] {
        TR_IDLE = 3'b001,
        TR_WAIT = 3'b010,
        TR_CATCH = 3'b100
    } csfp_tr_state_t;

    typedef struct packed {
        logic ov;
        logic z;
        logic ac;
        logic c;
    } csfp_flags_t;

    typedef struct packed {
        logic valid;
        csfp_op_t op;
        logic [7:0] a;
        logic [7:0] b;
    } csfp_alu_req_t;

endpackage

// >>> csfp_flag_calc.sv
// Combinational ALU result and flag computation
`timescale 1ns/10ps
`default_nettype none
module csfp_flag_calc (
    input wire csfp_pkg::csfp_op_t op, // Operation
    input wire logic [7:0] a, // First operand
    input wire logic [7:0] b, // Second operand
    input wire logic carryIn, // Current carry flag
    output logic [7:0] result, // Operation result
    output csfp_pkg::csfp_flags_t flags, // New flag values
    output logic [3:0] update // Flags this operation changes
);
    import csfp_pkg::*;

    logic [7:0] bx;
    logic cin;
    logic [4:0] lo5;
    logic [7:0] s7;
    logic [8:0] s9;

    always_comb begin
        bx = b;
        cin = 1'b0;
        // Subtraction adds the complement, so carry out means no borrow
        if (op == OP_ADC) begin
            cin = carryIn;
        end else if (op == OP_SUB) begin
            bx = ~b;
            cin = 1'b1;
        end else if (op == OP_SBC) begin
            bx = ~b;
            cin = carryIn;
        end
        lo5 = {1'b0, a[3:0]} + {1'b0, bx[3:0]} + {4'h0, cin};
        s7 = {1'b0, a[6:0]} + {1'b0, bx[6:0]} + {7'h00, cin};
        s9 = {1'b0, a} + {1'b0, bx} + {8'h00, cin};
        result = s9[7:0];
        flags.c = s9[8];
        flags.ac = lo5[4];
        flags.ov = s7[7] ^ s9[8];
        update = UPD_ARITH;
        case (op)
            OP_RLC: begin
                result = {a[6:0], carryIn};
                flags.c = a[7];
                update = UPD_ROT;
            end
            OP_RRC: begin
                result = {carryIn, a[7:1]};
                flags.c = a[0];
                update = UPD_ROT;
            end
            OP_AND: begin
                result = a & b;
                update = UPD_LOGIC;
            end
            OP_OR: begin
                result = a | b;
                update = UPD_LOGIC;
            end
            OP_XOR: begin
                result = a ^ b;
                update = UPD_LOGIC;
            end
            default: begin
            end
        endcase
        flags.z = (result == 8'h00);
    end

endmodule
`default_nettype wire

// >>> cpu_status_flags_and_pointers_test.sv
// Self-checking testbench for the CPU status flags and pointers block
`timescale 1ns/10ps
`default_nettype none
module cpu_status_flags_and_pointers_test;
    import csfp_pkg::*;
    logic clock, rst, psel, penable, pwrite, pcStep, halt, wdtRefresh, wdtTimeout, tblReadReq;
    logic [7:0] paddr, tblDest, aluResult, dmAddr, dmData, a, b, dst;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, dummyCycle, pmRead, dmWrite, irq, err, downFlag, expFlag;
    logic [15:0] pmData, w;
    logic [PC_W-1:0] pc, pmAddr, tp;
    logic [11:0] res;
    logic [3:0] flg;
    logic [2:0] steps [6];
    csfp_alu_req_t aluReq;
    csfp_op_t op;
    int miscompares, samplesChecked;

    csfp_core csfp_core_i (.clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .aluReq(aluReq), .aluResult(aluResult), .pcStep(pcStep), .pc(pc), .dummyCycle(dummyCycle),
        .halt(halt), .wdtRefresh(wdtRefresh), .wdtTimeout(wdtTimeout), .tblReadReq(tblReadReq),
        .tblDest(tblDest), .pmAddr(pmAddr), .pmRead(pmRead), .pmData(pmData), .dmWrite(dmWrite),
        .dmAddr(dmAddr), .dmData(dmData), .irq(irq));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic close_out;
        $display("Comparisons %0d, mismatches %0d", samplesChecked, miscompares);
        if (miscompares == 0 && samplesChecked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Bounded wait for a strobe sampled high at a rising edge
    task automatic await(ref logic s);
        int n;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (s !== 1'b1 && n < 20);
        if (s !== 1'b1) begin
            miscompares++;
            close_out;
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        await(pready);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Reference ALU: result in the upper byte, flags {ov,z,ac,c} below
    function automatic logic [11:0] model(input csfp_op_t o, input logic [7:0] x, y, input logic [3:0] f);
        logic [8:0] s;
        logic [4:0] n;
        logic [7:0] yy, r;
        logic ci;
        yy = (o == OP_SUB || o == OP_SBC) ? ~y : y;
        ci = (o == OP_ADD) ? 1'b0 : (o == OP_SUB) ? 1'b1 : f[0];
        s = {1'b0, x} + {1'b0, yy} + 9'(ci);
        n = {1'b0, x[3:0]} + {1'b0, yy[3:0]} + 5'(ci);
        case (o)
            OP_ADD, OP_ADC, OP_SUB, OP_SBC: begin
                r = s[7:0];
                f = {(x[7] == yy[7]) && (s[7] != x[7]), r == 8'h00, n[4], s[8]};
            end
            OP_RLC: begin
                r = {x[6:0], f[0]};
                f[0] = x[7];
            end
            OP_RRC: begin
                r = {f[0], x[7:1]};
                f[0] = x[0];
            end
            default: begin
                r = (o == OP_AND) ? (x & y) : (o == OP_OR) ? (x | y) : (x ^ y);
                f[2] = (r == 8'h00);
            end
        endcase
        return {r, f};
    endfunction

    initial begin
        {rst, psel, penable, pwrite, pcStep, halt, wdtRefresh, wdtTimeout, tblReadReq} = 9'h100;
        paddr = 8'h00;
        pwdata = 32'h0;
        tblDest = 8'h00;
        pmData = 16'h0;
        aluReq = '0;
        flg = 4'h0;
        downFlag = 1'b0;
        expFlag = 1'b0;
        steps = '{3'b001, 3'b100, 3'b001, 3'b110, 3'b101, 3'b010};
        void'($urandom(32'h7996));
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 8'h20, 32'h0);
        chk(rd, 32'h0);
        chk(32'(err), 32'h1);
        apb(1'b1, 8'h24, 32'hffffffff);
        chk(32'(err), 32'h1);
        apb(1'b1, ADDR_STATUS, 32'hff);
        flg = 4'hf;
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(rd, 32'h0f);
        for (int i = 0; i < 36; i++) begin
            op = csfp_op_t'(4'(i % 9));
            a = (i == 0) ? 8'h80 : (i == 2) ? 8'h35 : 8'($urandom);
            b = (i == 0) ? 8'h80 : (i == 2) ? 8'h35 : 8'($urandom);
            @(posedge clock);
            aluReq <= '{valid: 1'b1, op: op, a: a, b: b};
            @(posedge clock);
            aluReq.valid <= 1'b0;
            res = model(op, a, b, flg);
            flg = res[3:0];
            apb(1'b0, ADDR_STATUS, 32'h0);
            chk(32'(aluResult), 32'(res[11:4]));
            chk(rd, {26'h0, expFlag, downFlag, flg});
        end
        for (int i = 0; i < 6; i++) begin
            @(posedge clock);
            {halt, wdtRefresh, wdtTimeout} <= steps[i];
            @(posedge clock);
            {halt, wdtRefresh, wdtTimeout} <= 3'b000;
            downFlag = steps[i][2] | (downFlag & ~steps[i][1]);
            expFlag = steps[i][0] | (expFlag & ~(steps[i][2] | steps[i][1]));
            if (i == 2) begin
                apb(1'b1, ADDR_STATUS, 32'h00);
                flg = 4'h0;
            end
            apb(1'b0, ADDR_STATUS, 32'h0);
            chk(rd, {26'h0, expFlag, downFlag, flg});
        end
        @(posedge clock);
        pcStep <= 1'b1;
        repeat (300) @(posedge clock);
        pcStep <= 1'b0;
        apb(1'b0, ADDR_PC, 32'h0);
        chk(rd, 32'd300);
        pcStep <= 1'b1;
        apb(1'b1, ADDR_PCL, 32'h34);
        #1;
        chk({dummyCycle, 18'h0, pc}, {1'b1, 18'h0, 13'h134});
        @(posedge clock);
        #1;
        chk({dummyCycle, 18'h0, pc}, {1'b0, 18'h0, 13'h134});
        @(posedge clock);
        pcStep <= 1'b0;
        #1;
        chk(32'(pc), 32'h135);
        for (int i = 0; i < 3; i++) begin
            tp = 13'($urandom);
            dst = 8'($urandom);
            w = 16'($urandom);
            apb(1'b1, ADDR_TABLE_POINTER_HIGH, {27'h0, tp[12:8]});
            apb(1'b1, ADDR_TABLE_POINTER_LOW, {24'h0, tp[7:0]});
            tblReadReq <= 1'b1;
            tblDest <= dst;
            @(posedge clock);
            tblReadReq <= 1'b0;
            await(pmRead);
            chk(32'(pmAddr), 32'(tp));
            pmData <= w;
            @(posedge clock);
            pmData <= ~w;
            await(dmWrite);
            chk({16'h0, dmAddr, dmData}, {16'h0, dst, w[7:0]});
            apb(1'b0, ADDR_TABLE_HIGH_BYTE, 32'h0);
            chk(rd, 32'(w[15:8]));
        end
        apb(1'b0, ADDR_EVT, 32'h0);
        chk(rd, 32'hf);
        chk(32'(irq), 32'h0);
        apb(1'b1, ADDR_MASK, 32'h4);
        repeat (2) @(posedge clock);
        chk(32'(irq), 32'h1);
        apb(1'b1, ADDR_EVT, 32'h4);
        repeat (2) @(posedge clock);
        chk(32'(irq), 32'h0);
        apb(1'b0, ADDR_EVT, 32'h0);
        chk(rd, 32'hb);
        close_out;
    end

    initial begin
        repeat (50000) @(posedge clock);
        miscompares++;
        close_out;
    end
endmodule
`default_nettype wire
